// ---- irq_enable_priority_ctrl.v ----
// interrupt enable, priority and vectoring controller
// Function
// - input count configurable from zero to fifteen
// - one enable, one priority bit per input
// - low registers exist when any input exists
// - high registers exist above seven inputs
// - bit seven of low enable gates everything
// - low enable bits 0-6 enable inputs 0-6
// - high enable bits 0-7 enable inputs 7-14
// - inputs 0-5 carry timer, uart, i2c sources
// - low priority bits 0-6, bit seven reserved
// - priority zero is low, one is high
// - decode requests, manage service entry and return
// - asynchronous reset, held about 100ns
// - reset clears enable and priority registers
// - low preempted only by high; high never
// - higher level wins, then lowest index
// - sample at instruction start, poll next; blocks
// - fixed vector per input, 0003H to 0073H
//
// The plain strobed port was left to the implementer.
`include "irq_ctrl_defs.vh"

module irq_enable_priority_ctrl #(
  parameter NUM_INPUTS = 15
) (
  input wire clk_sys,
  input wire reset,
  input wire [(NUM_INPUTS > 0 ? NUM_INPUTS : 1)-1:0] irq_request,
  input wire instr_start,
  input wire instr_is_return,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  output reg vector_call,
  output reg [15:0] vector_addr,
  output reg [3:0] vector_index,
  output reg irq_out
);

  localparam W = (NUM_INPUTS > 0) ? NUM_INPUTS : 1;
  localparam HAS_LOW = (NUM_INPUTS > 0) ? 1 : 0;
  localparam HAS_HIGH = (NUM_INPUTS > `LOW_REG_INPUTS) ? 1 : 0;

  // address decoding used by both write and read paths
  function addr_is;
    input [7:0] a;
    input [7:0] b;
    begin
      addr_is = (a == b);
    end
  endfunction

  reg [W-1:0] enable_reg;
  reg [W-1:0] level_reg;
  reg global_irq_enable_reg;
  reg [W-1:0] sample_reg;
  reg regs_written_reg;
  reg [1:0] svc_reg;
  reg [1:0] svc_next;
  reg [`ST_WIDTH-1:0] status_reg;
  reg [`ST_WIDTH-1:0] mask_reg;
  reg [7:0] rd_next;
  wire [W-1:0] eligible;
  wire [W-1:0] high_req;
  wire [W-1:0] low_req;
  wire high_found;
  wire low_found;
  wire [3:0] high_idx;
  wire [3:0] low_idx;
  wire [3:0] win_idx;
  wire [15:0] win_vec;
  wire win_high;
  wire may_take;
  wire take;
  wire ret_event;
  wire [`ST_WIDTH-1:0] st_set;
  wire [W-1:0] wr_en_bits;
  wire [W-1:0] wr_lv_bits;
  wire wr_en_low;
  wire wr_en_high;
  wire wr_lv_low;
  wire wr_lv_high;
  wire any_ctrl_write;

  assign wr_en_low = reg_write && addr_is(reg_addr, `ADDR_ENABLE_LOW) && (HAS_LOW == 1);
  assign wr_lv_low = reg_write && addr_is(reg_addr, `ADDR_PRIORITY_LOW) && (HAS_LOW == 1);
  assign wr_en_high = reg_write && addr_is(reg_addr, `ADDR_ENABLE_HIGH) && (HAS_HIGH == 1);
  assign wr_lv_high = reg_write && addr_is(reg_addr, `ADDR_PRIORITY_HIGH) && (HAS_HIGH == 1);
  assign any_ctrl_write = wr_en_low || wr_lv_low || wr_en_high || wr_lv_high;

  // per-bit write steering: bits 0-6 from the low register, 7-14 from the high
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bitmap
      if (g < `LOW_REG_INPUTS) begin : lo
        assign wr_en_bits[g] = wr_en_low;
        assign wr_lv_bits[g] = wr_lv_low;
      end else begin : hi
        assign wr_en_bits[g] = wr_en_high;
        assign wr_lv_bits[g] = wr_lv_high;
      end
    end
  endgenerate

  // vector width follows NUM_INPUTS; one enable, one level bit each
  generate
    for (g = 0; g < W; g = g + 1) begin : cfg
      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          enable_reg[g] <= 1'b0;
          level_reg[g] <= 1'b0;
        end else begin
          if (wr_en_bits[g] && NUM_INPUTS > 0) begin
            enable_reg[g] <= reg_wdata[(g < `LOW_REG_INPUTS) ? g : g - `LOW_REG_INPUTS];
          end
          if (wr_lv_bits[g] && NUM_INPUTS > 0) begin
            level_reg[g] <= reg_wdata[(g < `LOW_REG_INPUTS) ? g : g - `LOW_REG_INPUTS];
          end
        end
      end
    end
  endgenerate

  // global enable held in bit seven of the low enable register
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      global_irq_enable_reg <= 1'b0;
    end else if (wr_en_low) begin
      global_irq_enable_reg <= reg_wdata[`GLOBAL_EN_BIT];
    end
  end

  // sample at each instruction start; note writes to block the next poll
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sample_reg <= {W{1'b0}};
      regs_written_reg <= 1'b0;
    end else begin
      if (instr_start) begin
        // fresh sample each instruction, nothing held over
        sample_reg <= (NUM_INPUTS > 0) ? irq_request : {W{1'b0}};
      end
      if (instr_start) begin
        regs_written_reg <= any_ctrl_write;
      end else if (any_ctrl_write) begin
        regs_written_reg <= 1'b1;
      end
    end
  end

  // inputs 0-5 are the timer, uart and i2c sources when those exist
  // nothing passes with global enable clear
  assign eligible = sample_reg & enable_reg & {W{global_irq_enable_reg}};
  // level one is the high group
  assign high_req = eligible & level_reg;
  assign low_req = eligible & ~level_reg;

  irq_prio_pick #(.N(W)) pick_high (
    .req(high_req),
    .found(high_found),
    .index(high_idx)
  );

  irq_prio_pick #(.N(W)) pick_low (
    .req(low_req),
    .found(low_found),
    .index(low_idx)
  );

  // high group first, lowest index within a group
  assign win_high = high_found;
  assign win_idx = high_found ? high_idx : low_idx;

  irq_vector_rom vec_rom (
    .index(win_idx),
    .vector(win_vec)
  );

  // high may preempt low only; nothing preempts high
  // return or register write in progress blocks the poll
  assign may_take = win_high ? (svc_reg[1] == 1'b0) : (svc_reg == `SVC_IDLE);
  assign take = instr_start && (high_found || low_found) && may_take && !instr_is_return &&
                !regs_written_reg && !any_ctrl_write && (NUM_INPUTS > 0);
  assign ret_event = instr_start && instr_is_return && (svc_reg != `SVC_IDLE);

  // service level tracking for entry and return
  always @* begin
    svc_next = svc_reg;
    if (take) begin
      svc_next = win_high ? (svc_reg | `SVC_HIGH) : `SVC_LOW;
    end else if (ret_event) begin
      // return leaves the highest active level
      svc_next = svc_reg[1] ? (svc_reg & `SVC_LOW) : `SVC_IDLE;
    end
  end

  // asynchronous reset of the service state
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      svc_reg <= `SVC_IDLE;
      vector_call <= 1'b0;
      vector_addr <= 16'h0000;
      vector_index <= 4'h0;
    end else begin
      svc_reg <= svc_next;
      vector_call <= take;
      if (take) begin
        vector_addr <= win_vec;
        vector_index <= win_idx;
      end
    end
  end

  assign st_set = {ret_event, take};

  // sticky status: a set in the same cycle as a clear wins
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      status_reg <= {`ST_WIDTH{1'b0}};
      mask_reg <= {`ST_WIDTH{1'b0}};
      irq_out <= 1'b0;
    end else begin
      if (reg_write && addr_is(reg_addr, `ADDR_IRQ_STATUS)) begin
        status_reg <= (status_reg & ~reg_wdata[`ST_WIDTH-1:0]) | st_set;
      end else begin
        status_reg <= status_reg | st_set;
      end
      if (reg_write && addr_is(reg_addr, `ADDR_IRQ_MASK)) begin
        mask_reg <= reg_wdata[`ST_WIDTH-1:0];
      end
      // one cycle behind the status, kept registered for a clean output
      irq_out <= |(status_reg & mask_reg);
    end
  end

  // absent registers read zero; reserved priority bit seven reads zero
  integer k;
  always @* begin
    rd_next = 8'h00;
    if (addr_is(reg_addr, `ADDR_ENABLE_LOW) && HAS_LOW == 1) begin
      for (k = 0; k < `LOW_REG_INPUTS; k = k + 1) begin
        if (k < NUM_INPUTS) rd_next[k] = enable_reg[k];
      end
      rd_next[`GLOBAL_EN_BIT] = global_irq_enable_reg;
    end else if (addr_is(reg_addr, `ADDR_PRIORITY_LOW) && HAS_LOW == 1) begin
      for (k = 0; k < `LOW_REG_INPUTS; k = k + 1) begin
        if (k < NUM_INPUTS) rd_next[k] = level_reg[k];
      end
    end else if (addr_is(reg_addr, `ADDR_ENABLE_HIGH) && HAS_HIGH == 1) begin
      for (k = `LOW_REG_INPUTS; k < `MAX_INPUTS; k = k + 1) begin
        if (k < NUM_INPUTS) rd_next[k - `LOW_REG_INPUTS] = enable_reg[k];
      end
    end else if (addr_is(reg_addr, `ADDR_PRIORITY_HIGH) && HAS_HIGH == 1) begin
      for (k = `LOW_REG_INPUTS; k < `MAX_INPUTS; k = k + 1) begin
        if (k < NUM_INPUTS) rd_next[k - `LOW_REG_INPUTS] = level_reg[k];
      end
    end else if (addr_is(reg_addr, `ADDR_IRQ_STATUS)) begin
      rd_next[`ST_WIDTH-1:0] = status_reg;
    end else if (addr_is(reg_addr, `ADDR_IRQ_MASK)) begin
      rd_next[`ST_WIDTH-1:0] = mask_reg;
    end else if (addr_is(reg_addr, `ADDR_SVC_STATE)) begin
      rd_next[1:0] = svc_reg;
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_next : 8'h00;
    end
  end

endmodule // irq_enable_priority_ctrl

// ---- irq_ctrl_defs.vh ----
// constants for the interrupt enable and priority controller
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// register addresses (8-bit special function register space)
`define ADDR_ENABLE_LOW 8'hA8
`define ADDR_PRIORITY_LOW 8'hB8
`define ADDR_ENABLE_HIGH 8'hE8
`define ADDR_PRIORITY_HIGH 8'hF8
`define ADDR_IRQ_STATUS 8'hC0
`define ADDR_IRQ_MASK 8'hC1
`define ADDR_SVC_STATE 8'hC2

// reset value of the enable and priority registers
`define REG_RESET 8'h00
// global enable position inside the low enable register
`define GLOBAL_EN_BIT 7
// inputs served by the low registers
`define LOW_REG_INPUTS 7
// largest number of request inputs
`define MAX_INPUTS 15

// vector address layout
`define VEC_BASE 16'h0003
`define VEC_PAIR_STEP 16'h0010
`define VEC_ODD_STEP 16'h0005

// status bits
`define ST_ACCEPT 0
`define ST_RETURN 1
`define ST_WIDTH 2

// service state codes
`define SVC_IDLE 2'h0
`define SVC_LOW 2'h1
`define SVC_HIGH 2'h2
`define SVC_BOTH 2'h3

// reset hold time in ns and the derived minimum high (asserted) time in cycles
`define RESET_MIN_NS 100
`define CLK_PERIOD_NS 5
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- irq_prio_pick.v ----
// fixed-order pick of the lowest-numbered request in a request vector
module irq_prio_pick #(
  parameter N = 15
) (
  input wire [N-1:0] req,
  output reg found,
  output reg [3:0] index
);

  integer i;

  // scan from the top so the lowest index wins last
  always @* begin
    found = 1'b0;
    index = 4'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        found = 1'b1;
        index = i[3:0];
      end
    end
  end

endmodule // irq_prio_pick

// ---- irq_vector_rom.v ----
// vector address for an accepted request index
`include "irq_ctrl_defs.vh"

module irq_vector_rom (
  input wire [3:0] index,
  output wire [15:0] vector
);

  // pairs of inputs sit 16 bytes apart, odd inputs 5 bytes after the even one
  assign vector = `VEC_BASE + ({12'h000, index[3:1]} * `VEC_PAIR_STEP) + (index[0] ? `VEC_ODD_STEP : 16'h0000);

endmodule // irq_vector_rom

// ---- irq_ctrl_checker.sv ----
// port assertions for the interrupt enable and priority controller
`include "irq_ctrl_defs.vh"
module irq_ctrl_checker #(parameter NUM_INPUTS = 15) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic instr_start,
  input wire logic instr_is_return,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic vector_call,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0] vector_index,
  input wire logic irq_out
);
  logic [15:0] en_reg;
  logic [15:0] en_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // shadow of the enables, delayed so it lines up with the call pulse
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      en_reg <= 16'h0000;
      en_d <= 16'h0000;
    end else begin
      if (reg_write && reg_addr == `ADDR_ENABLE_LOW) en_reg[7:0] <= reg_wdata;
      if (reg_write && reg_addr == `ADDR_ENABLE_HIGH) en_reg[15:8] <= reg_wdata;
      en_d <= en_reg;
    end
  end
  a_call_on_instr: assert property (vector_call |-> $past(instr_start)) else $error("call without start");
  a_no_call_return: assert property (vector_call |-> !$past(instr_is_return)) else $error("call on return");
  a_vector_table: assert property (vector_call |-> vector_addr == `VEC_BASE + {11'h000, vector_index[3:1], 4'h0}
    + (vector_index[0] ? `VEC_ODD_STEP : 16'h0000)) else $error("bad vector address");
  a_index_range: assert property (vector_call |-> vector_index < NUM_INPUTS) else $error("index out of range");
  a_vector_held: assert property (!vector_call |-> $stable(vector_addr)) else $error("vector moved");
  a_enable_gate: assert property (vector_call |-> en_d[7]
    && en_d[vector_index + {3'h0, vector_index > 4'h6}]) else $error("disabled input called");
  a_unmapped_zero: assert property ($past(reg_read) && !($past(reg_addr) inside {`ADDR_ENABLE_LOW,
    `ADDR_PRIORITY_LOW, `ADDR_ENABLE_HIGH, `ADDR_PRIORITY_HIGH, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK,
    `ADDR_SVC_STATE}) |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_reserved_bit: assert property ($past(reg_read) && $past(reg_addr) == `ADDR_PRIORITY_LOW
    |-> !reg_rdata[7]) else $error("reserved bit set");
  a_reset_clear: assert property ($fell(reset) |-> !vector_call && !irq_out) else $error("outputs after reset");
  cover property (vector_call && vector_index == 4'hE);
  cover property ($past(reg_read) && reg_rdata != 8'h00);
  cover property (irq_out);
endmodule // irq_ctrl_checker
bind irq_enable_priority_ctrl irq_ctrl_checker #(.NUM_INPUTS(NUM_INPUTS)) chk_i (.clk_sys, .reset, .instr_start,
  .instr_is_return, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .vector_call, .vector_addr,
  .vector_index, .irq_out);

// ---- cpu_core_model.sv ----
// instruction stream model of the cpu core
module cpu_core_model #(parameter GAP = 3) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ret_req,
  output logic instr_start = 1'b0,
  output logic instr_is_return = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // one start every GAP cycles; the return flag toggles off the pulse
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      instr_start <= 1'b0;
      instr_is_return <= 1'b0;
    end else begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      instr_start <= (cnt == GAP - 1);
      instr_is_return <= (cnt == GAP - 1) ? ret_req : ~instr_is_return;
    end
  end
endmodule // cpu_core_model

// ---- irq_enable_priority_ctrl_bench.sv ----
// self-checking bench for the interrupt enable and priority controller
`include "irq_ctrl_defs.vh"
module irq_enable_priority_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, reg_write = 0, reg_read = 0, ret_req = 0, rd_d = 0;
  logic instr_start, instr_is_return, vector_call, irq_out;
  logic [14:0] irq_request = 15'h0000;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, w;
  logic [15:0] vector_addr;
  logic [3:0] vector_index;
  logic [16:0] exp_q[$];
  logic [7:0] ra[4] = '{`ADDR_ENABLE_LOW, `ADDR_PRIORITY_LOW, `ADDR_ENABLE_HIGH, `ADDR_PRIORITY_HIGH};
  logic [7:0] rm[4] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF};
  int miscompares = 0, n_compared = 0, cycles = 0, seed;
  always #2.5 clk_sys = ~clk_sys;
  cpu_core_model cpu (.clk_sys, .reset, .ret_req, .instr_start, .instr_is_return);
  irq_enable_priority_ctrl dut (.clk_sys, .reset, .irq_request, .instr_start, .instr_is_return, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .vector_call, .vector_addr, .vector_index, .irq_out);
  task chk(input logic [16:0] e, input logic [16:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task tally_and_finish;
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // strobes drop a cycle early so no task sets one twice in a time step
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({9'h000, e});
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task expv(input int i);
    exp_q.push_back({1'b1, `VEC_BASE + 16'(i >> 1) * `VEC_PAIR_STEP + 16'(i & 1) * `VEC_ODD_STEP});
  endtask
  task instr(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      while (instr_start !== 1'b1) @(posedge clk_sys);
    end
  endtask
  task ret;
    ret_req <= 1'b1;
    instr(1);
    ret_req <= 1'b0;
  endtask
  // oldest note against each read answer or vector call
  always @(posedge clk_sys) begin
    rd_d <= reg_read;
    if (rd_d || vector_call === 1'b1) chk(exp_q.size() ? exp_q.pop_front() : 17'h1FFFF,
      rd_d ? {9'h000, reg_rdata} : {1'b1, vector_addr});
  end
  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    seed = 32'h7db4;
    // reset held high for the minimum asserted time
    repeat (`RESET_MIN_CYCLES) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      w = 8'($random(seed));
      rd(ra[k], 8'h00);
      wr(ra[k], w);
      rd(ra[k], w & rm[k]);
    end
    rd(8'h55, 8'h00);
    wr(`ADDR_ENABLE_LOW, 8'hFF);
    wr(`ADDR_ENABLE_HIGH, 8'hFF);
    instr(2);
    for (int i = 0; i < 15; i++) begin
      expv(i);
      irq_request <= 15'h0001 << i;
      instr(3);
      irq_request <= 15'h0000;
      instr(2);
      ret();
    end
    rd(`ADDR_IRQ_STATUS, 8'h03);
    chk(17'h00000, {16'h0000, irq_out});
    wr(`ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk(17'h00001, {16'h0000, irq_out});
    wr(`ADDR_IRQ_STATUS, 8'h03);
    repeat (2) @(posedge clk_sys);
    chk(17'h00000, {16'h0000, irq_out});
    wr(`ADDR_ENABLE_LOW, 8'h7F);
    instr(2);
    irq_request <= 15'h0001;
    instr(3);
    irq_request <= 15'h0000;
    wr(`ADDR_ENABLE_LOW, 8'hFF);
    instr(4);
    wr(`ADDR_PRIORITY_LOW, 8'h08);
    instr(2);
    expv(3);
    irq_request <= 15'h002A;
    instr(3);
    irq_request <= 15'h0022;
    instr(3);
    expv(1);
    ret();
    instr(3);
    irq_request <= 15'h0020;
    instr(3);
    expv(3);
    irq_request <= 15'h0028;
    instr(3);
    irq_request <= 15'h0000;
    ret();
    ret();
    instr(2);
    tally_and_finish();
  end
endmodule // irq_enable_priority_ctrl_bench
